// [src/tpc_pkg.sv]
package tpc_pkg;

	// register addresses on the special function register bus
	localparam logic [7:0]  ADDR_PWM_CFG     = 8'ha1;
	localparam logic [7:0]  ADDR_MODE        = 8'hed;
	// compare/reload byte pairs: low byte at base + stride*n, high byte one above
	localparam logic [7:0]  ADDR_CMP_BASE    = 8'hc0;
	localparam logic [7:0]  ADDR_CMP_STRIDE  = 8'h02;
	localparam int          NUM_MODULES      = 3;

	// mode register fields
	localparam int          MODE_IDLE_BIT    = 7;
	localparam int          MODE_TB_LSB      = 1;
	localparam int          MODE_OVF_EN_BIT  = 0;
	localparam logic [7:0]  MODE_WMASK       = 8'h8f;
	localparam logic [7:0]  MODE_RESET       = 8'h00;

	// pwm cycle configuration register fields
	localparam int          PWM_RELOAD_BIT   = 7;
	localparam int          PWM_COV_EN_BIT   = 6;
	localparam int          PWM_COV_FLAG_BIT = 5;
	localparam int          PWM_CL_LSB       = 0;
	localparam logic [7:0]  PWM_WMASK        = 8'hc3;
	localparam logic [7:0]  PWM_RESET        = 8'h00;

	localparam logic [15:0] CMP_RESET        = 16'h0000;
	localparam logic [15:0] CNT_RESET        = 16'h0000;
	localparam logic [15:0] CNT_LAST         = 16'hffff;

	// timebase select codes
	localparam logic [2:0]  TB_DIV12         = 3'h0;
	localparam logic [2:0]  TB_DIV4          = 3'h1;
	localparam logic [2:0]  TB_TIMER0        = 3'h2;
	localparam logic [2:0]  TB_EXT_FALL      = 3'h3;
	localparam logic [2:0]  TB_SYSCLK        = 3'h4;
	localparam logic [2:0]  TB_EXT_DIV8      = 3'h5;

	// prescaler terminal counts (count runs 0..last)
	localparam logic [3:0]  DIV12_LAST       = 4'hb;
	localparam logic [3:0]  DIV4_LAST        = 4'h3;
	localparam logic [2:0]  EXT_DIV8_LAST    = 3'h7;

	// cycle length codes and the counter bits that form one pwm cycle
	localparam logic [1:0]  CL_8BIT          = 2'h0;
	localparam logic [1:0]  CL_9BIT          = 2'h1;
	localparam logic [1:0]  CL_10BIT         = 2'h2;
	localparam logic [15:0] CYC_MASK_8       = 16'h00ff;
	localparam logic [15:0] CYC_MASK_9       = 16'h01ff;
	localparam logic [15:0] CYC_MASK_10      = 16'h03ff;
	localparam logic [15:0] CYC_MASK_11      = 16'h07ff;

endpackage : tpc_pkg

// [src/tpc_timebase.sv]
`timescale 1ns/1ns
// turns the selected timebase source into one-cycle count ticks
module tpc_timebase (
	input  wire logic       ref_clk,          // system clock
	input  wire logic       rst,              // synchronous reset, active high
	input  wire logic       ce,               // clock enable, freezes all state when low
	input  wire logic       suspend,          // hold prescalers and ticks
	input  wire logic [2:0] timebase_select,  // source code
	input  wire logic       timer0_overflow,  // one-cycle pulse from timer 0
	input  wire logic       ext_count_pin,    // external count input, asynchronous
	input  wire logic       ext_clk_pin,      // external clock, asynchronous
	output logic            tick              // one-cycle count pulse
);

	logic [1:0] eci_sync_q;
	logic       eci_last_q;
	logic [1:0] ext_sync_q;
	logic       ext_last_q;
	logic [3:0] div_q;
	logic [2:0] ext_div_q;
	logic       eci_fall;
	logic       ext_rise;
	logic       run;
	logic       tick_d;

	// two-stage synchronisers; edge detection only reads the second stage
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			eci_sync_q <= 2'h0;
			eci_last_q <= 1'b0;
			ext_sync_q <= 2'h0;
			ext_last_q <= 1'b0;
		end else if (ce) begin
			eci_sync_q <= {eci_sync_q[0], ext_count_pin};
			eci_last_q <= eci_sync_q[1];
			ext_sync_q <= {ext_sync_q[0], ext_clk_pin};
			ext_last_q <= ext_sync_q[1];
		end
	end

	assign eci_fall = eci_last_q & ~eci_sync_q[1];
	assign ext_rise = ext_sync_q[1] & ~ext_last_q;
	assign run      = ce & ~suspend;

	// system clock prescaler, terminal count follows the selected divide
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			div_q <= 4'h0;
		end else if (run) begin
			if ((timebase_select == tpc_pkg::TB_DIV12 && div_q >= tpc_pkg::DIV12_LAST) ||
			    (timebase_select == tpc_pkg::TB_DIV4 && div_q >= tpc_pkg::DIV4_LAST)) begin
				div_q <= 4'h0;
			end else begin
				div_q <= div_q + 4'h1;
			end
		end
	end

	// external clock divided by 8, counted in the system clock domain
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ext_div_q <= 3'h0;
		end else if (run && ext_rise) begin
			ext_div_q <= ext_div_q + 3'h1;
		end
	end

	// source select; reserved codes never tick
	always_comb begin
		case (timebase_select)
			tpc_pkg::TB_DIV12:    tick_d = (div_q >= tpc_pkg::DIV12_LAST);
			tpc_pkg::TB_DIV4:     tick_d = (div_q >= tpc_pkg::DIV4_LAST);
			tpc_pkg::TB_TIMER0:   tick_d = timer0_overflow;
			tpc_pkg::TB_EXT_FALL: tick_d = eci_fall;
			tpc_pkg::TB_SYSCLK:   tick_d = 1'b1;
			tpc_pkg::TB_EXT_DIV8: tick_d = ext_rise && ext_div_q == tpc_pkg::EXT_DIV8_LAST;
			default:              tick_d = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tick <= 1'b0;
		end else if (ce) begin
			tick <= tick_d & ~suspend;
		end
	end

endmodule : tpc_timebase

// [src/tpc_top.sv]
`timescale 1ns/1ns
module tpc_top (
	input  wire logic        ref_clk,                // system clock, 125 mhz
	input  wire logic        rst,                    // synchronous reset, active high
	input  wire logic        ce,                     // clock enable, freezes all state
	input  wire logic [7:0]  sfr_addr,               // register address
	input  wire logic        sfr_wr,                 // write strobe, one cycle
	input  wire logic        sfr_rd,                 // read strobe, one cycle
	input  wire logic [7:0]  sfr_wdata,              // write data
	output logic      [7:0]  sfr_rdata,              // read data, held until next read
	input  wire logic        cpu_idle,               // core is in idle mode
	input  wire logic        counter_run,            // run control for the shared counter
	input  wire logic        timer0_overflow,        // one-cycle pulse from timer 0
	input  wire logic        external_count_input,   // count pin, asynchronous
	input  wire logic        external_clock_input,   // external clock pin, asynchronous
	input  wire logic        counter_overflow_clear, // software clear of the counter flag
	input  wire logic [2:0]  module_pwm_enable,      // per module pwm mode bit
	input  wire logic [2:0]  module_pwm16,           // per module 16-bit pwm bit
	output logic      [15:0] shared_array_counter,   // running counter value
	output logic             counter_overflow_flag,  // sticky 16-bit rollover flag
	output logic             cycle_wrap,             // pulse, one cycle after nth-bit overflow
	output logic      [47:0] module_compare_value,   // compare values, module 0 in low bits
	output logic             array_irq               // interrupt request, level
);

	// software-visible configuration and the sticky flags
	logic [7:0]  mode_q;
	logic [7:0]  pwm_q;
	logic        cycle_overflow_flag_q;
	logic        cycle_overflow_flag_d;
	logic        cf_q;
	logic        cf_d;

	// shared counter and per-module storage
	logic [15:0] cnt_q;
	logic [15:0] cmp_q [tpc_pkg::NUM_MODULES];
	logic [15:0] reload_q [tpc_pkg::NUM_MODULES];
	logic [7:0]  view_low [tpc_pkg::NUM_MODULES];
	logic [7:0]  view_high [tpc_pkg::NUM_MODULES];

	// read path and registered outputs
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;
	logic        irq_q;
	logic        wrap_q;

	// counting and overflow detection
	logic        suspend;
	logic        tick;
	logic        advance;
	logic [15:0] cyc_mask;
	logic        nbit_ovf;
	logic        full_ovf;

	// decoded fields, write strobes and interrupt requests
	logic        wr_mode;
	logic        wr_pwm;
	logic        reload_sel;
	logic [1:0]  cycle_length;
	logic        idle_suspend;
	logic [2:0]  timebase_select;
	logic        counter_overflow_irq_enable;
	logic        cycle_overflow_irq_enable;
	logic        counter_irq_req;
	logic        cycle_irq_req;

	// decoded configuration fields
	assign idle_suspend                = mode_q[tpc_pkg::MODE_IDLE_BIT];
	assign timebase_select             = mode_q[tpc_pkg::MODE_TB_LSB +: 3];
	assign counter_overflow_irq_enable = mode_q[tpc_pkg::MODE_OVF_EN_BIT];
	assign reload_sel                  = pwm_q[tpc_pkg::PWM_RELOAD_BIT];
	assign cycle_overflow_irq_enable   = pwm_q[tpc_pkg::PWM_COV_EN_BIT];
	assign cycle_length                = pwm_q[tpc_pkg::PWM_CL_LSB +: 2];

	// idle pauses the array only when software asked for it
	assign suspend = idle_suspend & cpu_idle;

	// register write decodes, one strobe per configuration register
	assign wr_mode = sfr_wr && sfr_addr == tpc_pkg::ADDR_MODE;
	assign wr_pwm  = sfr_wr && sfr_addr == tpc_pkg::ADDR_PWM_CFG;

	// timebase prescaler and source select
	tpc_timebase u_timebase (
		.ref_clk         (ref_clk),
		.rst             (rst),
		.ce              (ce),
		.suspend         (suspend),
		.timebase_select (timebase_select),
		.timer0_overflow (timer0_overflow),
		.ext_count_pin   (external_count_input),
		.ext_clk_pin     (external_clock_input),
		.tick            (tick)
	);

	// a tick already registered when idle begins is dropped here as well
	assign advance = tick & counter_run & ~suspend;

	// bits of the counter that make up one pwm cycle
	always_comb begin
		case (cycle_length)
			tpc_pkg::CL_8BIT:  cyc_mask = tpc_pkg::CYC_MASK_8;
			tpc_pkg::CL_9BIT:  cyc_mask = tpc_pkg::CYC_MASK_9;
			tpc_pkg::CL_10BIT: cyc_mask = tpc_pkg::CYC_MASK_10;
			default:           cyc_mask = tpc_pkg::CYC_MASK_11;
		endcase
	end

	// overflow out of bit n happens when the low n bits are all ones and advance
	assign nbit_ovf = advance && (cnt_q & cyc_mask) == cyc_mask;
	assign full_ovf = advance && cnt_q == tpc_pkg::CNT_LAST;

	// shared 16-bit counter
	// no software write path here; the counter byte registers sit outside this block
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt_q <= tpc_pkg::CNT_RESET;
		end else if (ce && advance) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	// mode register: only writable bits are stored, so unused bits stay zero
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode_q <= tpc_pkg::MODE_RESET;
		end else if (ce && wr_mode) begin
			mode_q <= sfr_wdata & tpc_pkg::MODE_WMASK;
		end
	end

	// pwm configuration register, flag bit held separately
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pwm_q <= tpc_pkg::PWM_RESET;
		end else if (ce && wr_pwm) begin
			pwm_q <= sfr_wdata & tpc_pkg::PWM_WMASK;
		end
	end

	// cycle overflow flag: hardware set wins over a same-cycle software clear
	// a write of 1 sets it too, so software can force a cycle interrupt
	always_comb begin
		cycle_overflow_flag_d = cycle_overflow_flag_q;
		if (wr_pwm) begin
			cycle_overflow_flag_d = sfr_wdata[tpc_pkg::PWM_COV_FLAG_BIT];
		end
		if (nbit_ovf) begin
			cycle_overflow_flag_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cycle_overflow_flag_q <= 1'b0;
		end else if (ce) begin
			cycle_overflow_flag_q <= cycle_overflow_flag_d;
		end
	end

	// counter overflow flag: set wins over the clear input
	// the clear is a strobe from the control register decode outside this block
	assign cf_d = full_ovf | (cf_q & ~counter_overflow_clear);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cf_q <= 1'b0;
		end else if (ce) begin
			cf_q <= cf_d;
		end
	end

	// per module compare and reload storage
	for (genvar n = 0; n < tpc_pkg::NUM_MODULES; n++) begin : g_mod
		localparam logic [7:0] LOW_ADDR  = 8'(tpc_pkg::ADDR_CMP_BASE + tpc_pkg::ADDR_CMP_STRIDE * n);
		localparam logic [7:0] HIGH_ADDR = 8'(LOW_ADDR + 8'h01);
		logic wr_low;
		logic wr_high;
		logic reload_mode;

		assign wr_low  = sfr_wr && sfr_addr == LOW_ADDR;
		assign wr_high = sfr_wr && sfr_addr == HIGH_ADDR;
		// 16-bit modules and the 8-bit cycle never use the reload copy
		assign reload_mode = module_pwm_enable[n] & ~module_pwm16[n]
			& (cycle_length != tpc_pkg::CL_8BIT);

		// reload copy, reached only with reload-select set
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				reload_q[n] <= tpc_pkg::CMP_RESET;
			end else if (ce && reload_sel) begin
				if (wr_low) begin
					reload_q[n][7:0] <= sfr_wdata;
				end
				if (wr_high) begin
					reload_q[n][15:8] <= sfr_wdata;
				end
			end
		end

		// compare register; a software write in the same cycle overrides the reload
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				cmp_q[n] <= tpc_pkg::CMP_RESET;
			end else if (ce) begin
				if (nbit_ovf && reload_mode) begin
					cmp_q[n] <= reload_q[n];
				end
				if (!reload_sel && wr_low) begin
					cmp_q[n][7:0] <= sfr_wdata;
				end
				if (!reload_sel && wr_high) begin
					cmp_q[n][15:8] <= sfr_wdata;
				end
			end
		end

		assign module_compare_value[16*n +: 16] = cmp_q[n];

		// what the core sees at this module's byte addresses
		assign view_low[n]  = reload_sel ? reload_q[n][7:0] : cmp_q[n][7:0];
		assign view_high[n] = reload_sel ? reload_q[n][15:8] : cmp_q[n][15:8];
	end

	// read multiplexer; unmapped addresses read zero
	always_comb begin
		rdata_d = 8'h00;
		if (sfr_addr == tpc_pkg::ADDR_MODE) begin
			rdata_d = mode_q;
		end else if (sfr_addr == tpc_pkg::ADDR_PWM_CFG) begin
			rdata_d = pwm_q;
			rdata_d[tpc_pkg::PWM_COV_FLAG_BIT] = cycle_overflow_flag_q;
		end
		for (int n = 0; n < tpc_pkg::NUM_MODULES; n++) begin
			if (sfr_addr == 8'(tpc_pkg::ADDR_CMP_BASE + tpc_pkg::ADDR_CMP_STRIDE * n)) begin
				rdata_d = view_low[n];
			end else if (sfr_addr == 8'(tpc_pkg::ADDR_CMP_BASE
					+ tpc_pkg::ADDR_CMP_STRIDE * n + 1)) begin
				rdata_d = view_high[n];
			end
		end
	end

	// read data is captured on the strobe and held so the core can sample late
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else if (ce && sfr_rd) begin
			rdata_q <= rdata_d;
		end
	end

	// each flag asks for the shared interrupt only through its own enable bit
	assign counter_irq_req = cf_q & counter_overflow_irq_enable;
	assign cycle_irq_req   = cycle_overflow_flag_q & cycle_overflow_irq_enable;

	// interrupt request registered so the output comes straight from a flop
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_q <= counter_irq_req | cycle_irq_req;
		end
	end

	// cycle boundary pulse for the pwm output stages
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wrap_q <= 1'b0;
		end else if (ce) begin
			wrap_q <= nbit_ovf;
		end
	end

	// every output is a plain copy of its flop
	assign sfr_rdata             = rdata_q;
	assign shared_array_counter  = cnt_q;
	assign counter_overflow_flag = cf_q;
	assign cycle_wrap            = wrap_q;
	assign array_irq             = irq_q;

endmodule : tpc_top

// [tb/tpc_cpu_model.sv]
`timescale 1ns/1ns
// processor side of the register bus; strobes last one cycle, lines scrambled when idle
module tpc_cpu_model (
	input  wire logic       ref_clk,   // system clock
	input  wire logic [7:0] sfr_rdata, // read data from the block
	output logic      [7:0] sfr_addr,  // register address
	output logic            sfr_wr,    // write strobe
	output logic            sfr_rd,    // read strobe
	output logic      [7:0] sfr_wdata  // write data
);
	initial begin
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
	end
	// released lines show the inverse so a stale value is never mistaken for data
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge ref_clk);
		sfr_wr <= 1'b0;
		sfr_addr <= ~a;
		sfr_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge ref_clk);
		sfr_rd <= 1'b0;
		sfr_addr <= ~a;
		#1;
		d = sfr_rdata;
	endtask : rd
endmodule : tpc_cpu_model

// [tb/tpc_top_chk.sv]
`timescale 1ns/1ns
// port-level checks of the counter, flags and register reads
module tpc_top_chk (
	input wire logic        ref_clk,                // system clock
	input wire logic        rst,                    // synchronous reset
	input wire logic        ce,                     // clock enable
	input wire logic [7:0]  sfr_addr,               // register address
	input wire logic        sfr_wr,                 // write strobe
	input wire logic        sfr_rd,                 // read strobe
	input wire logic [7:0]  sfr_wdata,              // write data
	input wire logic [7:0]  sfr_rdata,              // read data
	input wire logic        cpu_idle,               // core idle
	input wire logic        counter_run,            // counter run control
	input wire logic        counter_overflow_clear, // counter flag clear
	input wire logic [15:0] shared_array_counter,   // counter value
	input wire logic        counter_overflow_flag,  // counter flag
	input wire logic        cycle_wrap,             // cycle pulse
	input wire logic        array_irq               // interrupt request
);
	logic [7:0]  mode_q;
	logic [7:0]  pwm_q;
	logic [15:0] cyc_mask;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// shadow copies of the written settings; the flag bit is ignored here
	always_ff @(posedge ref_clk) begin
		if (rst) mode_q <= 8'h00;
		else if (ce && sfr_wr && sfr_addr == tpc_pkg::ADDR_MODE) mode_q <= sfr_wdata;
	end
	always_ff @(posedge ref_clk) begin
		if (rst) pwm_q <= 8'h00;
		else if (ce && sfr_wr && sfr_addr == tpc_pkg::ADDR_PWM_CFG) pwm_q <= sfr_wdata;
	end
	assign cyc_mask = 16'h07ff >> (2'h3 - pwm_q[1:0]);
	a_ovf_irq_on: assert property (counter_overflow_flag && mode_q[0] |=> array_irq)
		else $error("counter flag enabled but no interrupt");
	a_irq_masked: assert property (!mode_q[0] && !pwm_q[6] |=> !array_irq)
		else $error("interrupt while both enables are clear");
	a_ovf_sets: assert property (!$past(rst) && $past(shared_array_counter) == 16'hffff
		&& shared_array_counter == 16'h0000 |-> counter_overflow_flag)
		else $error("rollover did not set counter flag");
	a_ovf_sticky: assert property (counter_overflow_flag && !counter_overflow_clear
		|=> counter_overflow_flag)
		else $error("counter flag dropped without clear");
	a_wrap_follows: assert property (!$past(rst) && $changed(shared_array_counter)
		&& $stable(pwm_q[1:0]) && (shared_array_counter & cyc_mask) == 16'h0000
		|-> cycle_wrap)
		else $error("cycle overflow missed");
	a_wrap_cause: assert property (cycle_wrap
		|-> (shared_array_counter & $past(cyc_mask)) == 16'h0000)
		else $error("cycle pulse without overflow");
	a_reserved_hold: assert property ($past(mode_q[3:1]) >= 3'h6 && mode_q[3:1] >= 3'h6
		|=> $stable(shared_array_counter))
		else $error("counter moved on reserved source");
	a_idle_hold: assert property ((cpu_idle && mode_q[7])[*2]
		|=> $stable(shared_array_counter))
		else $error("counter moved during suspended idle");
	a_sysclk_step: assert property ((mode_q[3:1] == tpc_pkg::TB_SYSCLK && counter_run
		&& !cpu_idle)[*3] |=> shared_array_counter == $past(shared_array_counter) + 16'h0001)
		else $error("system clock source did not step");
	a_mode_unused: assert property (ce && sfr_rd && sfr_addr == tpc_pkg::ADDR_MODE
		|=> sfr_rdata[6:4] == 3'h0)
		else $error("mode unused bits not zero");
	a_pwm_unused: assert property (ce && sfr_rd && sfr_addr == tpc_pkg::ADDR_PWM_CFG
		|=> sfr_rdata[4:2] == 3'h0)
		else $error("pwm unused bits not zero");
	c_wrap: cover property (cycle_wrap && pwm_q[1:0] == 2'h3);
	c_irq: cover property (counter_overflow_flag && array_irq);
	c_reserved: cover property (mode_q[3:1] == 3'h6 && counter_run);
endmodule : tpc_top_chk
bind tpc_top tpc_top_chk chk (.ref_clk(ref_clk), .rst(rst), .ce(ce), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
	.cpu_idle(cpu_idle), .counter_run(counter_run),
	.counter_overflow_clear(counter_overflow_clear),
	.shared_array_counter(shared_array_counter), .counter_overflow_flag(counter_overflow_flag),
	.cycle_wrap(cycle_wrap), .array_irq(array_irq));

// [tb/tpc_top_tb.sv]
`timescale 1ns/1ns
// self-checking bench for the counter configuration block
module tpc_top_tb;
	logic        ref_clk;
	logic        rst;
	logic [7:0]  sfr_addr;
	logic        sfr_wr;
	logic        sfr_rd;
	logic [7:0]  sfr_wdata;
	logic [7:0]  sfr_rdata;
	logic        cpu_idle;
	logic        counter_run;
	logic        timer0_overflow;
	logic        ext_cnt;
	logic        ext_clk;
	logic        counter_overflow_clear;
	logic [2:0]  module_pwm_enable;
	logic [2:0]  module_pwm16;
	logic [15:0] cnt;
	logic        ovf_flag;
	logic        cycle_wrap;
	logic [47:0] cmp;
	logic        array_irq;
	logic [3:0]  stim_q;
	int          fail_count;
	int          comparisons;
	tpc_top DUT (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.cpu_idle(cpu_idle), .counter_run(counter_run), .timer0_overflow(timer0_overflow),
		.external_count_input(ext_cnt), .external_clock_input(ext_clk),
		.counter_overflow_clear(counter_overflow_clear), .module_pwm_enable(module_pwm_enable),
		.module_pwm16(module_pwm16), .shared_array_counter(cnt),
		.counter_overflow_flag(ovf_flag), .cycle_wrap(cycle_wrap),
		.module_compare_value(cmp), .array_irq(array_irq));
	tpc_cpu_model cpu (.ref_clk(ref_clk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata));
	always #4 ref_clk = ~ref_clk;
	// source patterns: timer 0 every 6, count pin falls every 6, external clock period 4
	always @(posedge ref_clk) begin
		stim_q <= (stim_q == 4'hb) ? 4'h0 : stim_q + 4'h1;
		timer0_overflow <= (stim_q == 4'h0) || (stim_q == 4'h6);
		ext_cnt <= (stim_q % 4'h6) < 4'h3;
		ext_clk <= stim_q[1];
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		cpu.rd(a, d);
		check("rdata", {8'h00, d}, {8'h00, e});
	endtask : rchk
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	// cycles until the counter next changes, capped so a stuck counter cannot hang
	task automatic gap(output int n);
		logic [15:0] v;
		n = 0;
		v = cnt;
		while (cnt === v && n < 100) begin
			tick(1);
			n++;
		end
	endtask : gap
	task automatic wrap_gap(output int n);
		n = 0;
		do begin
			tick(1);
			n++;
		end while (cycle_wrap !== 1'b1 && n < 3000);
	endtask : wrap_gap
	task automatic t_regs;
		rchk(tpc_pkg::ADDR_MODE, 8'h00);
		rchk(tpc_pkg::ADDR_PWM_CFG, 8'h00);
		cpu.wr(8'h55, 8'hff);
		rchk(8'h55, 8'h00);
		cpu.wr(tpc_pkg::ADDR_MODE, 8'hff);
		rchk(tpc_pkg::ADDR_MODE, 8'h8f);
		cpu.wr(tpc_pkg::ADDR_PWM_CFG, 8'hff);
		rchk(tpc_pkg::ADDR_PWM_CFG, 8'he3);
		cpu.wr(tpc_pkg::ADDR_PWM_CFG, 8'h00);
		rchk(tpc_pkg::ADDR_PWM_CFG, 8'h00);
	endtask : t_regs
	task automatic t_timebase;
		int exp_gap [6] = '{12, 4, 6, 6, 1, 32};
		int n;
		logic [15:0] v;
		for (int i = 0; i < 6; i++) begin
			cpu.wr(tpc_pkg::ADDR_MODE, {4'h0, 3'(i), 1'b0});
			gap(n);
			gap(n);
			gap(n);
			check("tick gap", 16'(n), 16'(exp_gap[i]));
		end
		cpu.wr(tpc_pkg::ADDR_MODE, 8'h0c);
		tick(3);
		v = cnt;
		tick(40);
		check("reserved hold", cnt, v);
	endtask : t_timebase
	task automatic t_idle;
		int n;
		logic [15:0] v;
		cpu.wr(tpc_pkg::ADDR_MODE, 8'h08);
		cpu_idle <= 1'b1;
		gap(n);
		gap(n);
		check("idle run", 16'(n), 16'h0001);
		cpu.wr(tpc_pkg::ADDR_MODE, 8'h88);
		tick(3);
		v = cnt;
		tick(20);
		check("idle hold", cnt, v);
		cpu_idle <= 1'b0;
		cpu.wr(tpc_pkg::ADDR_MODE, 8'h08);
	endtask : t_idle
	task automatic t_cycle;
		int n;
		module_pwm_enable <= 3'b011;
		module_pwm16 <= 3'b010;
		cpu.wr(8'hc0, 8'h34);
		cpu.wr(8'hc1, 8'h12);
		cpu.wr(tpc_pkg::ADDR_PWM_CFG, 8'h80);
		cpu.wr(8'hc0, 8'h56);
		cpu.wr(8'hc1, 8'h01);
		cpu.wr(8'hc2, 8'h78);
		rchk(8'hc0, 8'h56);
		cpu.wr(tpc_pkg::ADDR_PWM_CFG, 8'h00);
		rchk(8'hc1, 8'h12);
		tick(600);
		check("cmp0 8bit", cmp[15:0], 16'h1234);
		for (int cl = 0; cl < 4; cl++) begin
			cpu.wr(tpc_pkg::ADDR_PWM_CFG, 8'(cl));
			wrap_gap(n);
			wrap_gap(n);
			check("cycle len", 16'(n), 16'h0100 << cl);
			if (cl == 1) check("cmp0 reload", cmp[15:0], 16'h0156);
			if (cl == 1) check("cmp1 16bit", cmp[31:16], 16'h0000);
		end
		rchk(tpc_pkg::ADDR_PWM_CFG, 8'h23);
		check("irq masked", {15'h0000, array_irq}, 16'h0000);
		cpu.wr(tpc_pkg::ADDR_PWM_CFG, 8'h63);
		tick(2);
		check("irq cycle", {15'h0000, array_irq}, 16'h0001);
		cpu.wr(tpc_pkg::ADDR_PWM_CFG, 8'h03);
		rchk(tpc_pkg::ADDR_PWM_CFG, 8'h03);
		tick(2);
		check("irq cleared", {15'h0000, array_irq}, 16'h0000);
	endtask : t_cycle
	task automatic t_overflow;
		int n;
		n = 0;
		while (ovf_flag !== 1'b1 && n < 70000) begin
			tick(1);
			n++;
		end
		tick(2);
		check("flag set", {15'h0000, ovf_flag}, 16'h0001);
		check("irq off", {15'h0000, array_irq}, 16'h0000);
		cpu.wr(tpc_pkg::ADDR_MODE, 8'h09);
		tick(2);
		check("irq on", {15'h0000, array_irq}, 16'h0001);
		@(posedge ref_clk) counter_overflow_clear <= 1'b1;
		@(posedge ref_clk) counter_overflow_clear <= 1'b0;
		tick(2);
		check("flag clear", {15'h0000, ovf_flag}, 16'h0000);
		check("irq gone", {15'h0000, array_irq}, 16'h0000);
	endtask : t_overflow
	task automatic end_sim;
		if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		cpu_idle = 1'b0;
		counter_run = 1'b1;
		counter_overflow_clear = 1'b0;
		module_pwm_enable = 3'b000;
		module_pwm16 = 3'b000;
		stim_q = 4'h0;
		timer0_overflow = 1'b0;
		ext_cnt = 1'b0;
		ext_clk = 1'b0;
		fail_count = 0;
		comparisons = 0;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		t_regs();
		t_timebase();
		t_idle();
		t_cycle();
		t_overflow();
		end_sim();
	end
	// the full rollover dominates run time; allow well beyond it
	initial begin
		#800000;
		fail_count++;
		end_sim();
	end
endmodule : tpc_top_tb
